// ===== rtl/bus_txn_pkg.sv
// Shared constants and types of the bus transaction unit
// Contract
// - Memory status selects data, stack, program space
// - First instruction word fetch uses status 1101
// - Coprocessor memory data uses 1010 or 1011
// - Address at strobe rise; segment one cycle earlier
// - Odd bytes low lanes, even bytes high lanes
// - Byte memory writes duplicate byte on both halves
// - I/O transactions last at least four cycles
// - I/O status 0010/0011, system mode held
// - 16-bit I/O address; segment lines undefined
// - I/O bytes: standard low, special high lanes
// - Coprocessor transfers: three cycles, status 1110
// - Coprocessor words; flags byte low lane, byte
// - Acknowledge lasts eight cycles, five auto waits
// - Acknowledge status by request type, read word
// - Acknowledge captures 16-bit identifier before strobe rise
// - Acknowledge samples wait at two points
// - Internal and refresh keep data strobe high
// - Internal operation: arbitrary address, read, previous mode
// - Refresh drives 9-bit row, repeats previous lines
// - Wait ignored for internal and refresh
// - Release bus while coprocessor moves memory data
// - Memory transaction lasts three cycles plus waits
// - Wait sampled before data; each low adds cycle
`default_nettype none
package bus_txn_pkg;
  typedef enum logic [2:0] {
    K_MEM = 3'h0, K_IO = 3'h1, K_COPRO = 3'h2, K_ACK = 3'h3, K_INTERNAL = 3'h4, K_REFRESH = 3'h5
  } kind_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_SEG = 3'h4, S_ADDR = 3'h1, S_HOLD = 3'h3, S_STRB = 3'h2, S_LAST = 3'h6
  } state_t;
  // Memory space selectors
  localparam logic [1:0] SP_DATA = 2'h0;
  localparam logic [1:0] SP_STACK = 2'h1;
  localparam logic [1:0] SP_PROG = 2'h2;
  localparam logic [1:0] SP_FIRST = 2'h3;
  // Status codes
  localparam logic [3:0] ST_INTERNAL = 4'h0;
  localparam logic [3:0] ST_REFRESH = 4'h1;
  localparam logic [3:0] ST_IO_STD = 4'h2;
  localparam logic [3:0] ST_IO_SPEC = 4'h3;
  localparam logic [1:0] ST_ACK_HI = 2'h1;
  localparam logic [3:0] ST_MEM_DATA = 4'h8;
  localparam logic [3:0] ST_MEM_STACK = 4'h9;
  localparam logic [3:0] ST_COP_DATA = 4'hA;
  localparam logic [3:0] ST_COP_STACK = 4'hB;
  localparam logic [3:0] ST_PROG = 4'hC;
  localparam logic [3:0] ST_FIRST = 4'hD;
  localparam logic [3:0] ST_COPRO = 4'hE;
  localparam logic [3:0] ST_IDLE = 4'hF;
  // Cycle counts: extra strobe cycles and acknowledge auto waits
  localparam logic [1:0] MEM_STRB_EXTRA = 2'h0;
  localparam logic [1:0] IO_STRB_EXTRA = 2'h1;
  localparam logic [1:0] ACK_HOLD_CYC = 2'h2;
  localparam logic [1:0] ACK_STRB_EXTRA = 2'h2;
  localparam int MEM_CYCLES = 3;
  localparam int IO_MIN_CYCLES = 4;
  localparam int ACK_MIN_CYCLES = 8;
endpackage
`default_nettype wire

// ===== rtl/bus_lane_steer.sv
// Byte lane steering for write data and read capture
`timescale 1ns/1ps
`default_nettype none
module bus_lane_steer (
  // Transaction shape
  input wire bus_txn_pkg::kind_t i_kind,
  input wire logic i_byte,
  input wire logic i_addr0,
  input wire logic i_io_special,
  // Data
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] i_bus,
  output logic [15:0] o_wlane,
  output logic [15:0] o_rdata
);
  logic low;

  // Pick the lane a byte travels on
  always_comb begin
    case (i_kind)
      bus_txn_pkg::K_IO: low = !i_io_special;
      bus_txn_pkg::K_COPRO: low = 1'b1;
      default: low = i_addr0;
    endcase
  end

  // Place write data and take read data
  always_comb begin
    if (!i_byte) begin
      o_wlane = i_wdata;
      o_rdata = i_bus;
    end else begin
      if (i_kind == bus_txn_pkg::K_MEM) begin
        o_wlane = {i_wdata[7:0], i_wdata[7:0]};
      end else if (low) begin
        o_wlane = {8'h00, i_wdata[7:0]};
      end else begin
        o_wlane = {i_wdata[7:0], 8'h00};
      end
      o_rdata = low ? {8'h00, i_bus[7:0]} : {8'h00, i_bus[15:8]};
    end
  end
endmodule
`default_nettype wire

// ===== rtl/bus_txn_unit.sv
// Bus transaction sequencer driving the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module bus_txn_unit #(
  parameter bit SEGMENTED = 1'b0
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Request from the core
  input wire logic i_req,
  input wire bus_txn_pkg::kind_t i_kind,
  input wire logic [1:0] i_space,
  input wire logic i_copro,
  input wire logic [1:0] i_ack_type,
  input wire logic i_io_special,
  input wire logic i_write,
  input wire logic i_byte,
  input wire logic i_mode_normal,
  input wire logic [15:0] i_addr,
  input wire logic [6:0] i_seg,
  input wire logic [8:0] i_row,
  input wire logic [15:0] i_wdata,
  // Answer to the core
  output logic o_ready,
  output logic o_done,
  output logic o_rvalid,
  output logic [15:0] o_rdata,
  // Bus pins
  input wire logic [15:0] i_bus,
  input wire logic i_wait_n,
  output logic [15:0] o_bus,
  output logic o_bus_oe,
  output logic o_addr_valid_strobe_n,
  output logic o_data_strobe_n,
  output logic [3:0] o_status,
  output logic [6:0] o_seg,
  output logic o_read,
  output logic o_byte,
  output logic o_mode_normal
);
  typedef struct packed {
    bus_txn_pkg::state_t st;
    logic [1:0] cnt;
    bus_txn_pkg::kind_t kind;
    logic copro;
    logic write;
    logic byte_x;
    logic addr0;
    logic io_special;
    logic [15:0] wdata;
    logic as_n;
    logic ds_n;
    logic [3:0] status;
    logic [6:0] seg;
    logic [15:0] bus;
    logic oe;
    logic rd;
    logic bw;
    logic mode;
    logic [15:0] rdata;
    logic rvalid;
    logic done;
    logic ready;
  } regs_t;

  localparam regs_t REGS_RESET = '{
    st: bus_txn_pkg::S_IDLE, cnt: 2'h0, kind: bus_txn_pkg::K_INTERNAL, copro: 1'b0,
    write: 1'b0, byte_x: 1'b0, addr0: 1'b0, io_special: 1'b0, wdata: 16'h0000,
    as_n: 1'b1, ds_n: 1'b1, status: bus_txn_pkg::ST_IDLE, seg: 7'h00, bus: 16'h0000,
    oe: 1'b0, rd: 1'b1, bw: 1'b0, mode: 1'b0, rdata: 16'h0000, rvalid: 1'b0,
    done: 1'b0, ready: 1'b1
  };

  regs_t q;
  regs_t d;
  logic [15:0] wlane;
  logic [15:0] rsteer;
  logic moves;
  logic [3:0] req_status;

  // Lane steering on the latched transaction
  bus_lane_steer u_steer (
    .i_kind(q.kind),
    .i_byte(q.byte_x),
    .i_addr0(q.addr0),
    .i_io_special(q.io_special),
    .i_wdata(q.wdata),
    .i_bus(i_bus),
    .o_wlane(wlane),
    .o_rdata(rsteer)
  );

  // Data moves on every kind but internal and refresh
  assign moves = (q.kind != bus_txn_pkg::K_INTERNAL) && (q.kind != bus_txn_pkg::K_REFRESH);

  // Status code of an incoming request
  always_comb begin
    case (i_kind)
      bus_txn_pkg::K_MEM: begin
        case (i_space)
          bus_txn_pkg::SP_DATA: req_status = i_copro ? bus_txn_pkg::ST_COP_DATA : bus_txn_pkg::ST_MEM_DATA;
          bus_txn_pkg::SP_STACK: req_status = i_copro ? bus_txn_pkg::ST_COP_STACK : bus_txn_pkg::ST_MEM_STACK;
          bus_txn_pkg::SP_PROG: req_status = bus_txn_pkg::ST_PROG;
          default: req_status = bus_txn_pkg::ST_FIRST;
        endcase
      end
      bus_txn_pkg::K_IO: req_status = i_io_special ? bus_txn_pkg::ST_IO_SPEC : bus_txn_pkg::ST_IO_STD;
      bus_txn_pkg::K_COPRO: req_status = bus_txn_pkg::ST_COPRO;
      bus_txn_pkg::K_ACK: req_status = {bus_txn_pkg::ST_ACK_HI, i_ack_type};
      bus_txn_pkg::K_REFRESH: req_status = bus_txn_pkg::ST_REFRESH;
      default: req_status = bus_txn_pkg::ST_INTERNAL;
    endcase
  end

  // Next state of the whole unit
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.rvalid = 1'b0;
    case (q.st)
      bus_txn_pkg::S_IDLE: begin
        if (i_req) begin
          d.ready = 1'b0;
          d.kind = i_kind;
          d.copro = i_copro;
          d.write = i_write;
          d.byte_x = i_byte;
          d.addr0 = i_addr[0];
          d.io_special = i_io_special;
          d.wdata = i_wdata;
          d.status = req_status;
          d.oe = 1'b1;
          d.bus = i_addr;
          d.seg = 7'h00;
          case (i_kind)
            bus_txn_pkg::K_MEM: begin
              d.rd = !i_write;
              d.bw = i_byte;
              d.mode = i_mode_normal;
              if (SEGMENTED) begin
                d.seg = i_seg;
              end
            end
            bus_txn_pkg::K_IO: begin
              d.rd = !i_write;
              d.bw = i_byte;
              d.mode = 1'b0;
            end
            bus_txn_pkg::K_COPRO: begin
              d.oe = 1'b0;
              d.rd = !i_write;
              d.bw = i_byte;
              d.mode = i_mode_normal;
            end
            bus_txn_pkg::K_ACK: begin
              d.oe = 1'b0;
              d.byte_x = 1'b0;
              d.rd = 1'b1;
              d.bw = 1'b0;
              d.mode = 1'b0;
            end
            bus_txn_pkg::K_REFRESH: begin
              d.bus = {7'h00, i_row};
            end
            default: begin
              d.rd = 1'b1;
              d.seg = i_seg;
            end
          endcase
          if (SEGMENTED && i_kind == bus_txn_pkg::K_MEM) begin
            d.st = bus_txn_pkg::S_SEG;
          end else begin
            d.st = bus_txn_pkg::S_ADDR;
            d.as_n = 1'b0;
          end
        end
      end
      bus_txn_pkg::S_SEG: begin
        d.st = bus_txn_pkg::S_ADDR;
        d.as_n = 1'b0;
      end
      bus_txn_pkg::S_ADDR: begin
        d.as_n = 1'b1;
        d.oe = 1'b0;
        if (q.kind == bus_txn_pkg::K_ACK) begin
          d.st = bus_txn_pkg::S_HOLD;
          d.cnt = bus_txn_pkg::ACK_HOLD_CYC;
        end else begin
          d.st = bus_txn_pkg::S_STRB;
          d.cnt = (q.kind == bus_txn_pkg::K_IO) ? bus_txn_pkg::IO_STRB_EXTRA : bus_txn_pkg::MEM_STRB_EXTRA;
          d.ds_n = !moves;
          d.oe = moves && q.write && !(q.copro && q.kind == bus_txn_pkg::K_MEM);
          d.bus = wlane;
        end
      end
      bus_txn_pkg::S_HOLD: begin
        if (q.cnt != 2'h0) begin
          d.cnt = q.cnt - 2'h1;
        end else if (i_wait_n) begin
          d.st = bus_txn_pkg::S_STRB;
          d.cnt = bus_txn_pkg::ACK_STRB_EXTRA;
          d.ds_n = 1'b0;
        end
      end
      bus_txn_pkg::S_STRB: begin
        if (q.cnt != 2'h0) begin
          d.cnt = q.cnt - 2'h1;
        end else if (i_wait_n || !moves) begin
          d.st = bus_txn_pkg::S_LAST;
        end
      end
      bus_txn_pkg::S_LAST: begin
        d.st = bus_txn_pkg::S_IDLE;
        d.ds_n = 1'b1;
        d.oe = 1'b0;
        d.done = 1'b1;
        d.ready = 1'b1;
        if (moves && q.rd && !(q.copro && q.kind == bus_txn_pkg::K_MEM)) begin
          d.rdata = rsteer;
          d.rvalid = 1'b1;
        end
      end
      default: begin
        d = REGS_RESET;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= REGS_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign o_ready = q.ready;
  assign o_done = q.done;
  assign o_rvalid = q.rvalid;
  assign o_rdata = q.rdata;
  assign o_bus = q.bus;
  assign o_bus_oe = q.oe;
  assign o_addr_valid_strobe_n = q.as_n;
  assign o_data_strobe_n = q.ds_n;
  assign o_status = q.status;
  assign o_seg = q.seg;
  assign o_read = q.rd;
  assign o_byte = q.bw;
  assign o_mode_normal = q.mode;

  // Helper counters for transaction length and wait extension
  logic [4:0] len_q;
  logic waited_q;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      len_q <= 5'h00;
      waited_q <= 1'b0;
    end else begin
      if (q.st == bus_txn_pkg::S_IDLE || q.st == bus_txn_pkg::S_SEG) begin
        len_q <= 5'h00;
        waited_q <= 1'b0;
      end else begin
        len_q <= (len_q == 5'h1F) ? len_q : len_q + 5'h01;
        if (!i_wait_n && moves && (q.st == bus_txn_pkg::S_STRB || q.st == bus_txn_pkg::S_HOLD)) begin
          waited_q <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sequence wait_hit_s;
    q.st == bus_txn_pkg::S_STRB && q.cnt == 2'h0 && moves && !i_wait_n;
  endsequence

  sequence extra_cycle_s;
    q.st == bus_txn_pkg::S_STRB ##1 1'b1;
  endsequence

  a_first_fetch: assert property (q.st == bus_txn_pkg::S_ADDR && q.kind == bus_txn_pkg::K_MEM
    && $past(i_space) == bus_txn_pkg::SP_FIRST && !SEGMENTED |-> o_status == 4'hD)
    else $error("first fetch status wrong");
  a_io_status_mode: assert property (q.st != bus_txn_pkg::S_IDLE && q.kind == bus_txn_pkg::K_IO
    |-> !o_mode_normal && o_status[3:1] == 3'h1)
    else $error("I/O status or mode wrong");
  a_io_length: assert property (q.st == bus_txn_pkg::S_LAST && q.kind == bus_txn_pkg::K_IO
    |-> len_q >= 5'(bus_txn_pkg::IO_MIN_CYCLES - 1))
    else $error("I/O transaction too short");
  a_ack_length: assert property (q.st == bus_txn_pkg::S_LAST && q.kind == bus_txn_pkg::K_ACK
    |-> len_q >= 5'(bus_txn_pkg::ACK_MIN_CYCLES - 1))
    else $error("acknowledge too short");
  a_mem_length: assert property (q.st == bus_txn_pkg::S_LAST && q.kind == bus_txn_pkg::K_MEM && !waited_q
    |-> len_q == 5'(bus_txn_pkg::MEM_CYCLES - 1))
    else $error("memory transaction not three cycles");
  a_no_data_strobe: assert property (!moves && q.st != bus_txn_pkg::S_IDLE |-> o_data_strobe_n)
    else $error("data strobe active without data");
  a_copro_release: assert property (!o_data_strobe_n && q.copro && q.kind == bus_txn_pkg::K_MEM
    |-> !o_bus_oe)
    else $error("bus driven during coprocessor data");
  a_byte_dup: assert property (!o_data_strobe_n && q.kind == bus_txn_pkg::K_MEM && q.byte_x && q.write
    |-> o_bus[15:8] == o_bus[7:0])
    else $error("byte write not duplicated");
  a_wait_extend: assert property (wait_hit_s |=> extra_cycle_s)
    else $error("wait low did not add a cycle");
  a_refresh_row: assert property ($rose(q.st == bus_txn_pkg::S_ADDR) && q.kind == bus_txn_pkg::K_REFRESH
    |-> o_bus[15:9] == 7'h00 ##0 o_data_strobe_n [*3])
    else $error("refresh row or strobe wrong");
endmodule
`default_nettype wire

// ===== tb/bus_mem_model.sv
// Memory and peripheral model on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module bus_mem_model (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Bus as seen on the wires
  input wire logic [15:0] i_bus,
  input wire logic i_as_n,
  input wire logic i_ds_n,
  input wire logic i_read,
  input wire logic i_byte,
  input wire logic [3:0] i_status,
  // Stall control from the bench
  input wire logic [2:0] i_stalls,
  input wire logic i_wait_hold,
  // Answer
  output logic [15:0] o_bus,
  output logic o_wait_n,
  output logic [15:0] o_mem,
  // Instruction words a coprocessor would capture
  output logic [15:0] o_first,
  output logic [15:0] o_second
);
  logic [15:0] addr_q;
  logic [1:0] take_q;
  logic armed_q;
  logic [15:0] last_q;
  logic [2:0] cnt_q;
  // Latch address, store writes, count stall cycles from data strobe fall
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      addr_q <= 16'h0000;
      last_q <= 16'h0000;
      cnt_q <= 3'h0;
      o_mem <= 16'h0000;
      take_q <= 2'h0;
      armed_q <= 1'b0;
      o_first <= 16'h0000;
      o_second <= 16'h0000;
    end else begin
      last_q <= o_bus;
      // Follow a two-word instruction; refresh does not break the chain
      if (!i_as_n && i_status != bus_txn_pkg::ST_REFRESH) begin
        take_q <= (i_status == bus_txn_pkg::ST_FIRST) ? 2'h1
          : ((armed_q && i_status == bus_txn_pkg::ST_PROG) ? 2'h2 : 2'h0);
        armed_q <= (i_status == bus_txn_pkg::ST_FIRST);
      end
      if (!i_ds_n && i_read && take_q == 2'h1) begin
        o_first <= i_bus;
      end
      if (!i_ds_n && i_read && take_q == 2'h2) begin
        o_second <= i_bus;
      end
      if (!i_as_n) begin
        addr_q <= i_bus;
        cnt_q <= i_stalls;
      end
      if (!i_ds_n && cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end
      if (!i_ds_n && !i_read) begin
        if (!i_byte) begin
          o_mem <= i_bus;
        end else if (addr_q[0]) begin
          o_mem[7:0] <= i_bus[7:0];
        end else begin
          o_mem[15:8] <= i_bus[15:8];
        end
      end
    end
  end
  // Read data only while selected; otherwise a changing pattern
  assign o_bus = (!i_ds_n && i_read) ? o_mem : ~last_q;
  // Wait held low for the set count of data strobe cycles
  assign o_wait_n = !(i_wait_hold || (!i_ds_n && cnt_q != 3'h0));
endmodule
`default_nettype wire

// ===== tb/cpu_bus_transaction_unit_tb_top.sv
// Self-checking bench for the bus transaction unit
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_transaction_unit_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  bus_txn_pkg::kind_t kind = bus_txn_pkg::K_MEM;
  logic [1:0] space = 2'h0;
  logic copro = 1'b0;
  logic [1:0] ack_type = 2'h0;
  logic io_spec = 1'b0;
  logic wr = 1'b0;
  logic byt = 1'b0;
  logic mode_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [6:0] seg = 7'h15;
  logic [8:0] row = 9'h000;
  logic [15:0] wdata = 16'h0000;
  logic [2:0] stalls = 3'h0;
  logic hold = 1'b0;
  logic ready, done, rvalid, oe, as_n, ds_n, rd, by, md, wait_n;
  logic [15:0] rdata, dbus, mbus, mem;
  logic [3:0] status;
  logic [6:0] seg_o;
  wire logic [15:0] bus_w;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc;
  logic [3:0] st_s;
  logic [15:0] adr_s, lane_s;
  logic rd_s, by_s, md_s, ds_s, oe_ds;
  logic [15:0] first_w, second_w, dbus2, adr2_s;
  logic as2_n, rv_s;
  logic [6:0] seg2;
  logic [7:0] pre_s, post_s;
  assign bus_w = oe ? dbus : mbus;
  bus_txn_unit #(.SEGMENTED(1'b0)) DUT (.i_ref_clk(clk), .i_reset_n(rst_n), .i_req(req), .i_kind(kind),
    .i_space(space), .i_copro(copro), .i_ack_type(ack_type), .i_io_special(io_spec), .i_write(wr),
    .i_byte(byt), .i_mode_normal(mode_n), .i_addr(addr), .i_seg(seg), .i_row(row), .i_wdata(wdata),
    .o_ready(ready), .o_done(done), .o_rvalid(rvalid), .o_rdata(rdata), .i_bus(bus_w), .i_wait_n(wait_n),
    .o_bus(dbus), .o_bus_oe(oe), .o_addr_valid_strobe_n(as_n), .o_data_strobe_n(ds_n), .o_status(status),
    .o_seg(seg_o), .o_read(rd), .o_byte(by), .o_mode_normal(md));
  // Segmented variant watched alongside; it never drives the shared bus
  bus_txn_unit #(.SEGMENTED(1'b1)) DUT_SEG (.i_ref_clk(clk), .i_reset_n(rst_n), .i_req(req), .i_kind(kind),
    .i_space(space), .i_copro(copro), .i_ack_type(ack_type), .i_io_special(io_spec), .i_write(wr),
    .i_byte(byt), .i_mode_normal(mode_n), .i_addr(addr), .i_seg(seg), .i_row(row), .i_wdata(wdata),
    .o_ready(), .o_done(), .o_rvalid(), .o_rdata(), .i_bus(bus_w), .i_wait_n(wait_n),
    .o_bus(dbus2), .o_bus_oe(), .o_addr_valid_strobe_n(as2_n), .o_data_strobe_n(), .o_status(),
    .o_seg(seg2), .o_read(), .o_byte(), .o_mode_normal());
  bus_mem_model PART (.i_ref_clk(clk), .i_reset_n(rst_n), .i_bus(bus_w), .i_as_n(as_n), .i_ds_n(ds_n),
    .i_read(rd), .i_byte(by), .i_status(status), .i_stalls(stalls), .i_wait_hold(hold), .o_bus(mbus),
    .o_wait_n(wait_n), .o_mem(mem), .o_first(first_w), .o_second(second_w));
  // Clock generator
  always #10 clk = ~clk;
  // Compare and count
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic print_verdict();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One transaction, recording what the bus showed
  task automatic run(input bus_txn_pkg::kind_t k, input logic [1:0] sp, input logic w, input logic b,
                     input logic [15:0] a);
    @(negedge clk);
    kind = k;
    space = sp;
    wr = w;
    byt = b;
    addr = a;
    req = 1'b1;
    cyc = 0;
    ds_s = 1'b0;
    oe_ds = 1'b0;
    rv_s = 1'b0;
    do begin
      @(negedge clk);
      req = 1'b0;
      cyc++;
      if (!as_n) begin
        st_s = status;
        adr_s = dbus;
        rd_s = rd;
        by_s = by;
        md_s = md;
      end
      if (!ds_n) begin
        ds_s = 1'b1;
        oe_ds = oe_ds | oe;
        if (oe) lane_s = dbus;
      end
      if (rvalid === 1'b1) rv_s = 1'b1;
      if (cyc == 1) pre_s = {as2_n, seg2};
      if (cyc == 2) begin
        post_s = {as2_n, seg2};
        adr2_s = dbus2;
      end
    end while (!done && cyc < 40);
    // A transaction that never ends counts against the run
    if (done !== 1'b1) n_mismatch++;
  endtask
  // Memory status codes per space, length and address
  task automatic t_mem_space();
    logic [3:0] exp_st [6] = '{4'h8, 4'h9, 4'hC, 4'hD, 4'hA, 4'hB};
    for (int i = 0; i < 6; i++) begin
      copro = (i > 3);
      run(bus_txn_pkg::K_MEM, 2'(i % 4), i > 3, 1'b0, 16'h1230 + 16'(i));
      check("mem_status", {12'h000, st_s}, {12'h000, exp_st[i]});
      check("mem_cycles", 16'(cyc), 16'h0004);
      check("mem_addr", adr_s, 16'h1230 + 16'(i));
      check("seg_lines", {pre_s, post_s}, 16'h9515);
      check("seg_addr", adr2_s, 16'h1230 + 16'(i));
      if (i > 3) check("copro_release", {15'h0000, oe_ds}, 16'h0000);
    end
    copro = 1'b0;
  endtask
  // Byte lanes for memory writes and reads
  task automatic t_bytes();
    mode_n = 1'b1;
    wdata = 16'hA55A;
    run(bus_txn_pkg::K_MEM, 2'h0, 1'b1, 1'b0, 16'h0000);
    check("word_lane", lane_s, 16'hA55A);
    wdata = 16'h003C;
    run(bus_txn_pkg::K_MEM, 2'h0, 1'b1, 1'b1, 16'h0001);
    check("byte_dup", lane_s, 16'h3C3C);
    check("byte_odd_store", mem, 16'hA53C);
    wdata = 16'h00C3;
    run(bus_txn_pkg::K_MEM, 2'h0, 1'b1, 1'b1, 16'h0002);
    check("byte_even_store", mem, 16'hC33C);
    run(bus_txn_pkg::K_MEM, 2'h0, 1'b0, 1'b1, 16'h0001);
    check("read_odd", rdata, 16'h003C);
    run(bus_txn_pkg::K_MEM, 2'h0, 1'b0, 1'b1, 16'h0000);
    check("read_even", rdata, 16'h00C3);
    check("read_flags", {13'h0000, rd_s, by_s, md_s}, 16'h0007);
    check("read_valid", {15'h0000, rv_s}, 16'h0001);
  endtask
  // Wait stretches a memory read
  task automatic t_wait();
    stalls = 3'h2;
    run(bus_txn_pkg::K_MEM, 2'h1, 1'b0, 1'b0, 16'h0040);
    check("wait_cycles", 16'(cyc), 16'h0006);
    check("wait_data", rdata, mem);
    stalls = 3'h0;
  endtask
  // Standard and special I/O byte writes
  task automatic t_io();
    for (int s = 0; s < 2; s++) begin
      io_spec = s[0];
      stalls = s[0] ? 3'h3 : 3'h0;
      wdata = 16'h005A;
      run(bus_txn_pkg::K_IO, 2'h0, 1'b1, 1'b1, 16'h8001 + 16'(s));
      check("io_status", {12'h000, st_s}, 16'h0002 + 16'(s));
      check("io_mode", {15'h0000, md_s}, 16'h0000);
      check("io_addr", adr_s, 16'h8001 + 16'(s));
      check("io_seg", {9'h000, seg_o}, 16'h0000);
      check("io_cycles", 16'(cyc), 16'h0005 + 16'(2 * s));
      check("io_lane", {8'h00, s[0] ? lane_s[15:8] : lane_s[7:0]}, 16'h005A);
    end
    stalls = 3'h0;
  endtask
  // Coprocessor transfers: flags byte read and word write
  task automatic t_copro();
    logic [15:0] m;
    m = mem;
    run(bus_txn_pkg::K_COPRO, 2'h0, 1'b0, 1'b1, 16'h0000);
    check("cop_status", {12'h000, st_s}, 16'h000E);
    check("cop_cycles", 16'(cyc), 16'h0004);
    check("cop_flags", rdata, {8'h00, m[7:0]});
    check("cop_mode", {15'h0000, md_s}, 16'h0001);
    wdata = 16'h1234;
    run(bus_txn_pkg::K_COPRO, 2'h0, 1'b1, 1'b0, 16'h0000);
    check("cop_word", lane_s, 16'h1234);
  endtask
  // Acknowledge of every request type
  task automatic t_ack();
    logic [15:0] m;
    for (int t = 0; t < 4; t++) begin
      ack_type = 2'(t);
      stalls = (t == 3) ? 3'h4 : 3'h0;
      m = mem;
      run(bus_txn_pkg::K_ACK, 2'h0, 1'b0, 1'b0, 16'h0000);
      check("ack_status", {12'h000, st_s}, 16'h0004 + 16'(t));
      check("ack_flags", {13'h0000, rd_s, by_s, md_s}, 16'h0004);
      check("ack_cycles", 16'(cyc), (t == 3) ? 16'h000B : 16'h0009);
      check("ack_ident", rdata, m);
    end
    stalls = 3'h0;
  endtask
  // Refresh and internal operation with wait held low
  task automatic t_idle();
    wdata = 16'h0011;
    run(bus_txn_pkg::K_MEM, 2'h0, 1'b1, 1'b1, 16'h0003);
    hold = 1'b1;
    mode_n = 1'b0;
    row = 9'h1A5;
    run(bus_txn_pkg::K_REFRESH, 2'h0, 1'b0, 1'b0, 16'h0000);
    check("ref_row", {7'h00, adr_s[8:0]}, 16'h01A5);
    check("ref_flags", {13'h0000, rd_s, by_s, md_s}, 16'h0003);
    check("ref_cycles", 16'(cyc), 16'h0004);
    check("ref_strobe", {15'h0000, ds_s}, 16'h0000);
    check("ref_valid", {15'h0000, rv_s}, 16'h0000);
    run(bus_txn_pkg::K_INTERNAL, 2'h0, 1'b1, 1'b0, 16'h0077);
    check("int_read_mode", {14'h0000, rd_s, md_s}, 16'h0003);
    check("int_cycles", 16'(cyc), 16'h0004);
    check("int_strobe", {15'h0000, ds_s}, 16'h0000);
    check("int_seg", {9'h000, seg_o}, 16'h0015);
    hold = 1'b0;
  endtask
  // Coprocessor follows a two-word instruction across a refresh
  task automatic t_track();
    wdata = 16'h7E81;
    run(bus_txn_pkg::K_MEM, 2'h0, 1'b1, 1'b0, 16'h0010);
    run(bus_txn_pkg::K_MEM, 2'h3, 1'b0, 1'b0, 16'h0100);
    run(bus_txn_pkg::K_REFRESH, 2'h0, 1'b0, 1'b0, 16'h0000);
    run(bus_txn_pkg::K_MEM, 2'h2, 1'b0, 1'b0, 16'h0102);
    check("track_first", first_w, 16'h7E81);
    check("track_second", second_w, 16'h7E81);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    check("reset_lines", {ready, as_n, ds_n, status}, 7'h7F);
    t_mem_space();
    t_bytes();
    t_wait();
    t_io();
    t_copro();
    t_ack();
    t_idle();
    t_track();
    print_verdict();
  end
  // Watchdog against a hung handshake
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
